// ==== src/usr_uart.sv ====
`timescale 1ns/1ps
// Function
// RULE1 - LINE_CONTROL bit 7 banks offsets to divisor
// RULE2 - Offset 0 read pops receive FIFO
// RULE3 - Offset 0 write queues transmit byte
// RULE4 - Banked offset 0 is divisor low, reset 01
// RULE5 - Banked offset 4 is divisor high, reset 0
// RULE6 - Offset 4 holds seven interrupt enables
// RULE7 - Offset 8 read gives interrupt identification
// RULE8 - Offset 8 write goes to FIFO control
// RULE9 - Offset 14h line status, reset 60h
// RULE10 - Transmit enable register halts transmitter
// RULE11 - Scratch byte at 1Ch, no effect
// RULE12 - Unassigned offsets are reserved
// RULE13 - Sixteen byte receive and transmit FIFOs
// RULE14 - Receive trigger at 1, 4, 8, 14
// RULE15 - Fractional divider and oversampling registers
// RULE16 - Transmit pin bidirectional in smart card
// RULE17 - RTS doubles as RS-485 direction
// RULE18 - Software assigns pins before enabling clocks
// RULE19 - Divisor zero acts as one
// RULE20 - First bit in bit 0, upper zero
// RULE21 - Word aligned offsets, low byte meaningful
// RULE22 - Banking touches only offsets 0 and 4
module usr_uart
	import usr_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rxd,
	output logic txd_out,
	output logic txd_oe,
	input wire logic txd_in,
	output logic rts_n,
	input wire logic cts_n,
	output logic dtr_n,
	input wire logic dsr_n,
	input wire logic dcd_n,
	input wire logic ri_n
);
	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic [7:0] dll;
		logic [7:0] divisor_high_byte;
		logic [6:0] interrupt_enables;
		logic fifo_en;
		logic [1:0] trig;
		logic [7:0] line_control;
		logic [7:0] modem_control;
		logic [7:0] scratch_pad;
		logic [7:0] autobaud_control;
		logic [7:0] infrared_control;
		logic [7:0] fractional_divider;
		logic [7:0] oversampling_control;
		logic [7:0] transmit_enable;
		logic [7:0] sci;
		logic [7:0] mdc;
		logic [7:0] adr;
		logic [7:0] dly;
		logic [7:0] sync;
		logic oe;
		logic pe;
		logic fe;
		logic thre_int;
		logic tx_empty_d;
		logic [3:0] msr_prev;
		logic [3:0] msr_delta;
		usr_bit_t tx_st;
		logic [7:0] tx_sh;
		logic [2:0] tx_cnt;
		logic [3:0] tx_os;
		logic tx_par;
		logic tx_bit;
		usr_bit_t rx_st;
		logic [7:0] rx_sh;
		logic [2:0] rx_cnt;
		logic [3:0] rx_os;
		logic rx_par;
		logic rx_perr;
		logic txd;
		logic txd_oe;
		logic rts_n;
		logic dtr_n;
	} usr_state_t;

	localparam usr_state_t RST = '{
		dll: RST_DLL,
		fractional_divider: RST_FDR,
		oversampling_control: RST_OSR,
		transmit_enable: RST_TER,
		tx_empty_d: 1'b1,
		tx_st: USR_IDLE,
		rx_st: USR_IDLE,
		tx_bit: 1'b1,
		txd: 1'b1,
		txd_oe: 1'b1,
		rts_n: 1'b1,
		dtr_n: 1'b1,
		default: '0
	};

	usr_state_t s;
	usr_state_t next_s;

	logic tick;
	logic tx_push;
	logic tx_pop;
	logic tx_clr;
	logic [7:0] tx_rdata;
	logic tx_full;
	logic tx_empty;
	logic rx_push;
	logic rx_pop;
	logic rx_clr;
	logic [7:0] rx_rdata;
	logic [4:0] rx_level;
	logic rx_full;
	logic rx_empty;
	logic divisor_latch_select;
	logic hit;
	logic [7:0] rd;
	logic [4:0] trig_lvl;
	logic rls;
	logic rda;
	logic thp;
	logic [2:0] iid;
	logic [7:0] interrupt_identification;
	logic [7:0] line_status;
	logic [3:0] msr_now;
	logic [2:0] last_bit;
	logic [3:0] half;
	logic rx_src;

	usr_baud u_baud (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.fractional_divider(s.fractional_divider),
		.divisor({s.divisor_high_byte, s.dll}), // RULE5
		.tick(tick)
	);

	usr_fifo u_tx_fifo ( // RULE13
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.clr(tx_clr),
		.push(tx_push),
		.wdata(pwdata[7:0]),
		.pop(tx_pop),
		.rdata(tx_rdata),
		.level(),
		.full(tx_full),
		.empty(tx_empty)
	);

	usr_fifo u_rx_fifo ( // RULE13
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.clr(rx_clr),
		.push(rx_push),
		.wdata(s.rx_sh),
		.pop(rx_pop),
		.rdata(rx_rdata),
		.level(rx_level),
		.full(rx_full),
		.empty(rx_empty)
	);

	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign txd_out = s.txd;
	assign txd_oe = s.txd_oe;
	assign rts_n = s.rts_n;
	assign dtr_n = s.dtr_n;

	always_comb begin
		next_s = s;
		tx_push = 1'b0;
		tx_pop = 1'b0;
		tx_clr = 1'b0;
		rx_push = 1'b0;
		rx_pop = 1'b0;
		rx_clr = 1'b0;
		hit = 1'b0;
		rd = 8'h00;
		divisor_latch_select = s.line_control[LCR_DIVISOR_LATCH_SELECT]; // RULE1
		case (s.trig) // RULE14
			2'h0: trig_lvl = TRIG_LVL0;
			2'h1: trig_lvl = TRIG_LVL1;
			2'h2: trig_lvl = TRIG_LVL2;
			default: trig_lvl = TRIG_LVL3;
		endcase
		rls = s.interrupt_enables[IER_RLS] & (s.oe | s.pe | s.fe);
		rda = s.interrupt_enables[IER_RDA] & (rx_level >= trig_lvl);
		thp = s.interrupt_enables[IER_THRE] & s.thre_int;
		iid = rls ? IID_RLS : rda ? IID_RDA : thp ? IID_THRE : IID_NONE;
		interrupt_identification = {s.fifo_en, s.fifo_en, 2'h0, iid, ~(rls | rda | thp)}; // RULE7
		line_status = {s.oe | s.pe | s.fe, tx_empty & (s.tx_st == USR_IDLE), tx_empty, 1'b0,
			s.fe, s.pe, s.oe, ~rx_empty}; // RULE9
		msr_now = {~dcd_n, ~ri_n, ~dsr_n, ~cts_n};
		last_bit = 3'(s.line_control[1:0]) + 3'h4;
		half = {1'b0, s.oversampling_control[7:5]};
		// Smart card mode receives on the shared data pin
		rx_src = s.sci[SCI_EN] ? txd_in : rxd;

		// Banking only matters at offsets 0 and 4
		case (paddr) // RULE22
			OFS_DATA: begin
				hit = 1'b1;
				rd = divisor_latch_select ? s.dll : (rx_empty ? 8'h00 : rx_rdata); // RULE2
			end
			OFS_IER: begin
				hit = 1'b1;
				rd = divisor_latch_select ? s.divisor_high_byte : {1'b0, s.interrupt_enables}; // RULE5
			end
			OFS_IIR: begin
				hit = 1'b1;
				rd = interrupt_identification;
			end
			OFS_LCR: begin
				hit = 1'b1;
				rd = s.line_control;
			end
			OFS_MCR: begin
				hit = 1'b1;
				rd = s.modem_control;
			end
			OFS_LSR: begin
				hit = 1'b1;
				rd = line_status;
			end
			OFS_MSR: begin
				hit = 1'b1;
				rd = {msr_now, s.msr_delta};
			end
			OFS_SCR: begin
				hit = 1'b1;
				rd = s.scratch_pad; // RULE11
			end
			OFS_ACR: begin
				hit = 1'b1;
				rd = s.autobaud_control;
			end
			OFS_ICR: begin
				hit = 1'b1;
				rd = s.infrared_control;
			end
			OFS_FDR: begin
				hit = 1'b1;
				rd = s.fractional_divider;
			end
			OFS_OSR: begin
				hit = 1'b1;
				rd = s.oversampling_control;
			end
			OFS_TER: begin
				hit = 1'b1;
				rd = s.transmit_enable;
			end
			OFS_SCI: begin
				hit = 1'b1;
				rd = s.sci;
			end
			OFS_MDC: begin
				hit = 1'b1;
				rd = s.mdc;
			end
			OFS_ADR: begin
				hit = 1'b1;
				rd = s.adr;
			end
			OFS_DLY: begin
				hit = 1'b1;
				rd = s.dly;
			end
			OFS_SYNC: begin
				hit = 1'b1;
				rd = s.sync;
			end
			default: begin
				hit = 1'b0; // RULE12
				rd = 8'h00;
			end
		endcase

		// One wait state: data and error are registered on the same edge that raises pready
		if (psel && penable && !s.pready) begin
			next_s.pready = 1'b1;
			next_s.pslverr = ~hit; // RULE12
			next_s.prdata = {24'h000000, pwrite ? 8'h00 : rd}; // RULE21
		end
		if (psel && penable && s.pready) begin
			next_s.pready = 1'b0;
			next_s.pslverr = 1'b0;
			if (!s.pslverr && pwrite) begin
				case (paddr)
					OFS_DATA: begin
						if (divisor_latch_select) begin
							next_s.dll = pwdata[7:0]; // RULE4
						end else begin
							tx_push = 1'b1; // RULE3
							next_s.thre_int = 1'b0;
						end
					end
					OFS_IER: begin
						if (divisor_latch_select) begin
							next_s.divisor_high_byte = pwdata[7:0]; // RULE5
						end else begin
							next_s.interrupt_enables = pwdata[6:0]; // RULE6
							if (pwdata[IER_THRE] && !s.interrupt_enables[IER_THRE] && tx_empty) begin
								next_s.thre_int = 1'b1;
							end
						end
					end
					OFS_IIR: begin
						next_s.fifo_en = pwdata[FCR_EN]; // RULE8
						next_s.trig = pwdata[7:6];
						rx_clr = pwdata[FCR_RXCLR];
						tx_clr = pwdata[FCR_TXCLR];
					end
					OFS_LCR: next_s.line_control = pwdata[7:0];
					OFS_MCR: next_s.modem_control = pwdata[7:0];
					OFS_SCR: next_s.scratch_pad = pwdata[7:0]; // RULE11
					OFS_ACR: next_s.autobaud_control = pwdata[7:0];
					OFS_ICR: next_s.infrared_control = pwdata[7:0];
					OFS_FDR: next_s.fractional_divider = pwdata[7:0]; // RULE15
					OFS_OSR: next_s.oversampling_control = pwdata[7:0]; // RULE15
					OFS_TER: next_s.transmit_enable = pwdata[7:0]; // RULE10
					OFS_SCI: next_s.sci = pwdata[7:0];
					OFS_MDC: next_s.mdc = pwdata[7:0];
					OFS_ADR: next_s.adr = pwdata[7:0];
					OFS_DLY: next_s.dly = pwdata[7:0];
					OFS_SYNC: next_s.sync = pwdata[7:0];
					default: next_s.sync = s.sync;
				endcase
			end else if (!s.pslverr) begin
				case (paddr)
					OFS_DATA: rx_pop = ~divisor_latch_select; // RULE2
					OFS_IIR: begin
						if (iid == IID_THRE) begin
							next_s.thre_int = 1'b0;
						end
					end
					OFS_LSR: begin
						next_s.oe = 1'b0;
						next_s.pe = 1'b0;
						next_s.fe = 1'b0;
					end
					OFS_MSR: next_s.msr_delta = 4'h0;
					default: next_s.sync = s.sync;
				endcase
			end
		end

		// Events come after the clears so a same-cycle event survives
		next_s.msr_delta = next_s.msr_delta | (msr_now ^ s.msr_prev);
		next_s.msr_prev = msr_now;
		if (tx_empty && !s.tx_empty_d) begin
			next_s.thre_int = 1'b1;
		end
		next_s.tx_empty_d = tx_empty;

		if (tick) begin
			case (s.tx_st)
				USR_IDLE: begin
					next_s.tx_bit = 1'b1;
					// CTS gating only when auto flow is on
					if (!tx_empty && s.transmit_enable[TER_TXEN] && (!s.modem_control[MCR_CTSEN] || !cts_n)) begin // RULE10
						tx_pop = 1'b1;
						next_s.tx_sh = tx_rdata;
						next_s.tx_st = USR_START;
						next_s.tx_os = 4'h0;
						next_s.tx_par = 1'b0;
						next_s.tx_bit = 1'b0;
					end
				end
				default: begin
					next_s.tx_os = s.tx_os + 4'h1;
					if (s.tx_os == s.oversampling_control[7:4]) begin // RULE15
						next_s.tx_os = 4'h0;
						case (s.tx_st)
							USR_START, USR_DATA: begin
								if (s.tx_st == USR_DATA && s.tx_cnt == last_bit) begin
									next_s.tx_cnt = 3'h0;
									if (s.line_control[LCR_PEN]) begin
										next_s.tx_st = USR_PARITY;
										next_s.tx_bit = s.line_control[LCR_EVEN] ? s.tx_par : ~s.tx_par;
									end else begin
										next_s.tx_st = USR_STOP;
										next_s.tx_bit = 1'b1;
									end
								end else begin
									next_s.tx_cnt = (s.tx_st == USR_START) ? 3'h0 : s.tx_cnt + 3'h1;
									next_s.tx_st = USR_DATA;
									next_s.tx_bit = s.tx_sh[0];
									next_s.tx_par = s.tx_par ^ s.tx_sh[0];
									next_s.tx_sh = {1'b0, s.tx_sh[7:1]};
								end
							end
							USR_PARITY: begin
								next_s.tx_st = USR_STOP;
								next_s.tx_bit = 1'b1;
							end
							default: begin
								if (s.line_control[LCR_STOP2] && s.tx_cnt == 3'h0) begin
									next_s.tx_cnt = 3'h1;
								end else begin
									next_s.tx_cnt = 3'h0;
									next_s.tx_st = USR_IDLE;
								end
							end
						endcase
					end
				end
			endcase

			case (s.rx_st)
				USR_IDLE: begin
					if (!rx_src) begin
						next_s.rx_st = USR_START;
						next_s.rx_os = 4'h0;
					end
				end
				USR_START: begin
					next_s.rx_os = s.rx_os + 4'h1;
					// Mid-bit recheck rejects glitches
					if (s.rx_os == half) begin
						next_s.rx_os = 4'h0;
						next_s.rx_st = rx_src ? USR_IDLE : USR_DATA;
						next_s.rx_cnt = 3'h0;
						next_s.rx_sh = 8'h00; // RULE20
						next_s.rx_par = 1'b0;
						next_s.rx_perr = 1'b0;
					end
				end
				default: begin
					next_s.rx_os = s.rx_os + 4'h1;
					if (s.rx_os == s.oversampling_control[7:4]) begin
						next_s.rx_os = 4'h0;
						case (s.rx_st)
							USR_DATA: begin
								next_s.rx_sh[s.rx_cnt] = rx_src; // RULE20
								next_s.rx_par = s.rx_par ^ rx_src;
								next_s.rx_cnt = s.rx_cnt + 3'h1;
								if (s.rx_cnt == last_bit) begin
									next_s.rx_st = s.line_control[LCR_PEN] ? USR_PARITY : USR_STOP;
								end
							end
							USR_PARITY: begin
								next_s.rx_perr = rx_src != (s.line_control[LCR_EVEN] ? s.rx_par : ~s.rx_par);
								next_s.rx_st = USR_STOP;
							end
							default: begin
								next_s.rx_st = USR_IDLE;
								next_s.fe = next_s.fe | ~rx_src;
								next_s.pe = next_s.pe | s.rx_perr;
								next_s.oe = next_s.oe | rx_full;
								rx_push = ~rx_full;
							end
						endcase
					end
				end
			endcase
		end

		next_s.txd = next_s.tx_bit & ~next_s.line_control[LCR_BRK];
		// Smart card line is open drain: drive only the low level
		next_s.txd_oe = ~next_s.sci[SCI_EN] | ~next_s.txd; // RULE16
		next_s.rts_n = next_s.mdc[MDC_DCTRL] ?
			((next_s.tx_st == USR_IDLE) ^ next_s.mdc[MDC_OINV]) : ~next_s.modem_control[MCR_RTS]; // RULE17
		next_s.dtr_n = ~next_s.modem_control[MCR_DTR];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= RST;
		end else if (ce) begin
			s <= next_s;
		end
	end
endmodule : usr_uart

// ==== pkg/usr_pkg.sv ====
package usr_pkg;
	localparam logic [7:0] OFS_DATA = 8'h00;
	localparam logic [7:0] OFS_IER = 8'h04;
	localparam logic [7:0] OFS_IIR = 8'h08;
	localparam logic [7:0] OFS_LCR = 8'h0C;
	localparam logic [7:0] OFS_MCR = 8'h10;
	localparam logic [7:0] OFS_LSR = 8'h14;
	localparam logic [7:0] OFS_MSR = 8'h18;
	localparam logic [7:0] OFS_SCR = 8'h1C;
	localparam logic [7:0] OFS_ACR = 8'h20;
	localparam logic [7:0] OFS_ICR = 8'h24;
	localparam logic [7:0] OFS_FDR = 8'h28;
	localparam logic [7:0] OFS_OSR = 8'h2C;
	localparam logic [7:0] OFS_TER = 8'h30;
	localparam logic [7:0] OFS_SCI = 8'h48;
	localparam logic [7:0] OFS_MDC = 8'h4C;
	localparam logic [7:0] OFS_ADR = 8'h50;
	localparam logic [7:0] OFS_DLY = 8'h54;
	localparam logic [7:0] OFS_SYNC = 8'h58;

	localparam logic [7:0] RST_DLL = 8'h01;
	localparam logic [7:0] RST_FDR = 8'h10;
	localparam logic [7:0] RST_OSR = 8'hF0;
	localparam logic [7:0] RST_TER = 8'h80;

	localparam int DATA_W = 8;
	localparam int FIFO_DEPTH = 16;
	localparam int FIFO_AW = 4;
	localparam logic [4:0] TRIG_LVL0 = 5'h01;
	localparam logic [4:0] TRIG_LVL1 = 5'h04;
	localparam logic [4:0] TRIG_LVL2 = 5'h08;
	localparam logic [4:0] TRIG_LVL3 = 5'h0E;

	localparam int LCR_DIVISOR_LATCH_SELECT = 7;
	localparam int LCR_BRK = 6;
	localparam int LCR_EVEN = 4;
	localparam int LCR_PEN = 3;
	localparam int LCR_STOP2 = 2;
	localparam int MCR_DTR = 0;
	localparam int MCR_RTS = 1;
	localparam int MCR_CTSEN = 7;
	localparam int TER_TXEN = 7;
	localparam int SCI_EN = 0;
	localparam int MDC_DCTRL = 4;
	localparam int MDC_OINV = 5;
	localparam int FCR_EN = 0;
	localparam int FCR_RXCLR = 1;
	localparam int FCR_TXCLR = 2;
	localparam int IER_RDA = 0;
	localparam int IER_THRE = 1;
	localparam int IER_RLS = 2;

	localparam logic [2:0] IID_RLS = 3'h3;
	localparam logic [2:0] IID_RDA = 3'h2;
	localparam logic [2:0] IID_THRE = 3'h1;
	localparam logic [2:0] IID_NONE = 3'h0;

	typedef enum logic [2:0] {
		USR_IDLE = 3'b000,
		USR_START = 3'b001,
		USR_DATA = 3'b010,
		USR_PARITY = 3'b011,
		USR_STOP = 3'b100
	} usr_bit_t;
endpackage : usr_pkg

// ==== src/usr_fifo.sv ====
`timescale 1ns/1ps
module usr_fifo
	import usr_pkg::*;
#(
	parameter int WIDTH = DATA_W,
	parameter int DEPTH = FIFO_DEPTH,
	parameter int AW = FIFO_AW
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic clr,
	input wire logic push,
	input wire logic [WIDTH-1:0] wdata,
	input wire logic pop,
	output logic [WIDTH-1:0] rdata,
	output logic [AW:0] level,
	output logic full,
	output logic empty
);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} usr_fifo_t;

	usr_fifo_t s;
	usr_fifo_t next_s;
	logic do_push;
	logic do_pop;

	assign rdata = s.mem[s.rp];
	assign level = s.cnt;
	assign full = (s.cnt == (AW+1)'(DEPTH));
	assign empty = (s.cnt == '0);

	always_comb begin
		next_s = s;
		do_push = push & ~full;
		do_pop = pop & ~empty;
		if (do_push) begin
			next_s.mem[s.wp] = wdata;
			next_s.wp = s.wp + 1'b1;
		end
		if (do_pop) begin
			next_s.rp = s.rp + 1'b1;
		end
		next_s.cnt = s.cnt + (AW+1)'(do_push) - (AW+1)'(do_pop);
		if (clr) begin
			next_s.wp = '0;
			next_s.rp = '0;
			next_s.cnt = '0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
		end else if (ce) begin
			s <= next_s;
		end
	end
endmodule : usr_fifo

// ==== src/usr_baud.sv ====
`timescale 1ns/1ps
module usr_baud
	import usr_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic [7:0] fractional_divider,
	input wire logic [15:0] divisor,
	output logic tick
);
	typedef struct packed {
		logic [4:0] acc;
		logic [15:0] cnt;
		logic tick;
	} usr_baud_t;

	usr_baud_t s;
	usr_baud_t next_s;
	logic [4:0] sum;
	logic [4:0] mul;
	logic [15:0] top;

	assign tick = s.tick;

	always_comb begin
		next_s = s;
		next_s.tick = 1'b0;
		mul = {1'b0, fractional_divider[7:4]};
		sum = s.acc + {1'b0, fractional_divider[3:0]};
		// Zero divisor counts as one
		top = (divisor == 16'h0000) ? 16'h0000 : divisor - 16'h0001; // RULE19
		// Fraction swallows a clock on each overflow, stretching the period
		if (fractional_divider[3:0] != 4'h0 && sum >= mul) begin
			next_s.acc = sum - mul;
		end else begin
			next_s.acc = (fractional_divider[3:0] != 4'h0) ? sum : 5'h00;
			if (s.cnt >= top) begin
				next_s.cnt = 16'h0000;
				next_s.tick = 1'b1;
			end else begin
				next_s.cnt = s.cnt + 16'h0001;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
		end else if (ce) begin
			s <= next_s;
		end
	end
endmodule : usr_baud

// ==== verif/usr_monitor.sv ====
`timescale 1ns/1ps
module usr_monitor (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic txd_out,
	input wire logic txd_oe,
	input wire logic dtr_n
);
	logic acc;
	logic mapped;
	assign acc = psel && penable && pready;
	// Reserved hole between transmit enable and smart card control
	assign mapped = paddr[1:0] == 2'h0 && (paddr <= 8'h30 || (paddr >= 8'h48 && paddr <= 8'h58));
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	a_ready_wait: assert property (psel && penable && !pready && ce ##1 ce |-> pready)
		else $error("access phase not answered after one wait state");
	a_ready_pulse: assert property ($rose(pready) |=> !pready)
		else $error("ready held longer than one cycle");
	a_err_unmapped: assert property (acc && !mapped |-> pslverr)
		else $error("reserved offset answered without error");
	a_ok_mapped: assert property (acc && mapped |-> !pslverr)
		else $error("mapped offset answered with error");
	a_upper_zero: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0)
		else $error("read data upper bits not zero");
	a_iir_code: assert property (acc && !pwrite && paddr == 8'h08 |->
		prdata[0] == (prdata[3:1] == 3'h0))
		else $error("pending flag disagrees with identification code");
	a_lsr_idle: assert property (acc && !pwrite && paddr == 8'h14 |-> !prdata[6] || prdata[5])
		else $error("transmitter idle while holding not empty");
	a_dtr_follow: assert property (acc && pwrite && paddr == 8'h10 |->
		##2 dtr_n == !$past(pwdata[0], 2))
		else $error("terminal ready pin does not follow modem control");
	a_txd_drive: assert property (!txd_out |-> txd_oe)
		else $error("transmit low level not driven");
	a_reset_idle: assert property ($rose(presetn) |-> txd_out && txd_oe && !pready && dtr_n)
		else $error("outputs not idle after reset");
	c_error: cover property (acc && pslverr);
	c_tx_write: cover property (acc && pwrite && paddr == 8'h00);
	c_tx_low: cover property (!txd_out);
endmodule : usr_monitor

// ==== verif/usr_line_peer.sv ====
`timescale 1ns/1ps
module usr_line_peer #(
	parameter int BIT = 16
) (
	input wire logic pclk,
	input wire logic line_in,
	output logic line_out,
	output logic [7:0] got,
	output int got_n
);
	initial begin
		line_out = 1'b1;
		got = 8'h00;
		got_n = 0;
	end
	// Centre sampling tolerates a few cycles of start jitter
	always begin
		@(negedge line_in);
		repeat (BIT / 2) @(posedge pclk);
		if (line_in == 1'b0) begin
			for (int i = 0; i < 8; i++) begin
				repeat (BIT) @(posedge pclk);
				got[i] = line_in;
			end
			repeat (BIT) @(posedge pclk);
			got_n = got_n + 1;
		end
	end
	task automatic send(input logic [7:0] b, input int gap);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		repeat (gap) @(posedge pclk);
		for (int i = 0; i < 10; i++) begin
			line_out <= f[i];
			repeat (BIT) @(posedge pclk);
		end
	endtask : send
endmodule : usr_line_peer

// ==== verif/testbench.sv ====
`timescale 1ns/1ps
module testbench;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic ce = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic rxd;
	logic txd_out;
	logic txd_oe;
	logic txd_line;
	logic rts_n;
	logic dtr_n;
	logic [7:0] got;
	int got_n;
	int errors = 0;
	int checks = 0;
	logic [31:0] seed = 32'd54024;
	logic [7:0] m [0:127];
	logic [31:0] r;
	logic e;
	logic [7:0] bad [5] = '{8'h34, 8'h44, 8'h5C, 8'h02, 8'h0D};
	logic [7:0] rw [8] = '{8'h00, 8'h04, 8'h1C, 8'h20, 8'h24, 8'h50, 8'h54, 8'h58};
	int trg [4] = '{1, 4, 8, 14};
	// Pull-up on the transmit wire when nobody drives it
	assign txd_line = txd_oe ? txd_out : 1'b1;
	always #2 pclk = ~pclk;
	usr_uart u_dut (.*, .txd_in(txd_line), .cts_n(1'b1), .dsr_n(1'b1), .dcd_n(1'b1), .ri_n(1'b1));
	usr_line_peer u_peer (.pclk(pclk), .line_in(txd_line), .line_out(rxd), .got(got), .got_n(got_n));
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs
	function automatic int key(input logic [7:0] a);
		return (m[12][7] && a < 8) ? a + 1 : a;
	endfunction : key
	task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %s exp %h seen %h", s, exp, seen);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 40);
		chk("pready", {31'h0, pready}, 32'h1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		// Enable register keeps only seven bits
		m[key(a)] = (key(a) == 4) ? {1'b0, d[6:0]} : d[7:0];
	endtask : wr
	task automatic rdm(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
		chk($sformatf("reg %h", a), r, {24'h0, m[key(a)]});
	endtask : rdm
	task automatic rdx(input logic [7:0] a, input logic [7:0] x, input logic [7:0] mk);
		apb(1'b0, a, 32'h0);
		chk($sformatf("reg %h", a), r & {24'h0, mk}, {24'h0, x & mk});
	endtask : rdx
	task automatic txw(input int n);
		int t;
		t = 0;
		while (got_n < n && t < 3000) begin
			@(posedge pclk);
			t++;
		end
		chk("frames", 32'(got_n), 32'(n));
	endtask : txw
	task automatic print_verdict();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : print_verdict
	// Several times the expected run length
	initial begin
		#200000;
		errors++;
		print_verdict();
	end
	initial begin
		logic [7:0] b;
		logic [7:0] q [$];
		m = '{default: 8'h00};
		m[1] = 8'h01;
		m[8] = 8'h01;
		m[20] = 8'h60;
		m[40] = 8'h10;
		m[44] = 8'hF0;
		m[48] = 8'h80;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		ce <= 1'b1;
		@(posedge pclk);
		for (int a = 4; a <= 88; a += 4)
			if (a < 52 || a > 68) rdm(8'(a));
		foreach (bad[j]) begin
			apb(1'b0, bad[j], 32'h0);
			chk("reserved read", {e, r[30:0]}, 32'h8000_0000);
			apb(1'b1, bad[j], 32'hFF);
			chk("reserved write", {31'h0, e}, 32'h1);
		end
		apb(1'b1, 8'h14, 32'hFF);
		rdm(8'h14);
		for (int dl = 0; dl < 2; dl++) begin
			wr(8'h0C, dl ? 32'h83 : 32'h03);
			if (dl) rdm(8'h00);
			foreach (rw[j])
				if (dl || rw[j] != 8'h00) begin
					wr(rw[j], xs());
					rdm(rw[j]);
				end
		end
		wr(8'h00, 32'h0);
		wr(8'h04, 32'h0);
		wr(8'h0C, 32'h03);
		for (int i = 0; i < 3; i++) begin
			q.push_back(8'(xs()));
			wr(8'h00, {24'h0, q[i]});
		end
		for (int i = 1; i <= 3; i++) begin
			txw(i);
			chk("tx byte", {24'h0, got}, {24'h0, q.pop_front()});
		end
		repeat (20) @(posedge pclk);
		rdm(8'h14);
		b = 8'(xs());
		wr(8'h30, 32'h0);
		wr(8'h00, {24'h0, b});
		repeat (400) @(posedge pclk);
		chk("halted", 32'(got_n), 32'd3);
		rdx(8'h14, 8'h00, 8'h20);
		wr(8'h30, 32'h80);
		txw(4);
		chk("tx byte", {24'h0, got}, {24'h0, b});
		wr(8'h04, 32'h1);
		for (int lv = 0; lv < 4; lv++) begin
			wr(8'h08, (lv << 6) | 3);
			q.delete();
			for (int i = 1; i <= trg[lv] + (lv == 3 ? 3 : 0); i++) begin
				b = 8'(xs());
				if (i <= 16) q.push_back(b);
				u_peer.send(b, i * 3 % 17);
				if (i <= trg[lv]) rdx(8'h08, i == trg[lv] ? 8'h4 : 8'h1, 8'h0F);
			end
		end
		rdx(8'h14, 8'h03, 8'h03);
		while (q.size() > 0) begin
			apb(1'b0, 8'h00, 32'h0);
			chk("rx byte", r, {24'h0, q.pop_front()});
		end
		rdx(8'h14, 8'h00, 8'h01);
		wr(8'h0C, 32'h0);
		u_peer.send(b | 8'hE0, 0);
		apb(1'b0, 8'h00, 32'h0);
		chk("short rx", r, {27'h0, b[4:0]});
		wr(8'h10, 32'h3);
		repeat (2) @(posedge pclk);
		chk("modem pins", {30'h0, rts_n, dtr_n}, 32'h0);
		wr(8'h10, 32'h0);
		repeat (2) @(posedge pclk);
		chk("modem pins", {30'h0, rts_n, dtr_n}, 32'h3);
		wr(8'h48, 32'h1);
		repeat (2) @(posedge pclk);
		chk("txd enable", {31'h0, txd_oe}, 32'h0);
		wr(8'h48, 32'h0);
		repeat (2) @(posedge pclk);
		chk("txd enable", {31'h0, txd_oe}, 32'h1);
		wr(8'h4C, 32'h10);
		wr(8'h00, {24'h0, b});
		repeat (40) @(posedge pclk);
		chk("rs485 dir", {31'h0, rts_n}, 32'h0);
		txw(5);
		repeat (20) @(posedge pclk);
		chk("rs485 dir", {31'h0, rts_n}, 32'h1);
		print_verdict();
	end
endmodule : testbench
bind usr_uart usr_monitor u_mon (.*);
